/* common/fspc_defs.svh */
`ifndef FSPC_DEFS_SVH
`define FSPC_DEFS_SVH

// Register offsets on the plain register port
`define FSPC_ADDR_LO_OFS 4'h0
`define FSPC_ADDR_HI_OFS 4'h1
`define FSPC_GATE_OFS 4'h2
`define FSPC_CTRL_OFS 4'h3
`define FSPC_STAT_OFS 4'h4

// Control register field positions
`define FSPC_CTRL_PRG_BIT 0
`define FSPC_CTRL_ERS_BIT 1
`define FSPC_CTRL_SEL_LO_BIT 3
`define FSPC_CTRL_SEL_HI_BIT 4

// Reset values
`define FSPC_ADDR_RST 16'h0000
`define FSPC_CTRL_RST 8'h00

// Unlock key nibbles
`define FSPC_KEY_FIRST 4'h5
`define FSPC_KEY_SECOND 4'ha

// Timing: clock rate, divider base count and fixed portions
`define FSPC_CLK_HZ 25000000
`define FSPC_DIV_BASE_CYC 5000
`define FSPC_ERASE_FIX_US 9000
`define FSPC_WRITE_FIX_US 2000
`define FSPC_ERASE_FIX_CYC ((`FSPC_ERASE_FIX_US * (`FSPC_CLK_HZ / 1000000)))
`define FSPC_WRITE_FIX_CYC ((`FSPC_WRITE_FIX_US * (`FSPC_CLK_HZ / 1000000)))

// RAM window copied by a page write
`define FSPC_RAM_BASE 16'h0300
`define FSPC_RAM_LAST 16'h033f
`define FSPC_PAGE_BYTES 7'd64

`endif

/* common/fspc_pkg.sv */
package fspc_pkg;

  typedef enum logic [1:0] {
    FSPC_OP_NONE,
    FSPC_OP_WRITE,
    FSPC_OP_ERASE
  } fspc_op_t;

  // Request to the flash array
  typedef struct packed {
    logic erase_pulse;
    logic write_pulse;
    logic [15:0] addr;
    logic [7:0] data;
  } fspc_flash_req_t;

  // RAM read request
  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } fspc_ram_req_t;

endpackage : fspc_pkg

/* verilog/fspc_counter.sv */
`timescale 1ns/1ps
// Down counter: loads a count, pulses done when it reaches zero
module fspc_counter #(
  parameter int W = 24
) (
  input wire logic clock_in, // System clock
  input wire logic reset_in, // Async reset, active high
  input wire logic load_in, // Load start value
  input wire logic [W-1:0] value_in, // Start value
  input wire logic tick_in, // Decrement enable
  output logic done_out // One-cycle pulse at zero
);

  logic [W-1:0] cnt_r;
  logic run_r;
  wire at_one = (cnt_r == W'(1));

  // Count down on each tick while running
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (load_in) begin
      cnt_r <= value_in;
      run_r <= 1'b1;
    end else if (run_r && tick_in) begin
      cnt_r <= cnt_r - W'(1);
      if (at_one) run_r <= 1'b0;
    end
  end

  assign done_out = run_r && tick_in && at_one;

endmodule : fspc_counter

/* verilog/fspc_ctrl.sv */
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`include "fspc_defs.svh"

// Notes on behaviour
// [R1] Erase uses address bits 15:10 only
// [R2] Unimplemented register bits read as one
// [R3] Gate opens after nibble 5 then A
// [R4] Gate closes after every operation
// [R5] Control writes need the open gate
// [R6] Software unlocks again before each operation
// [R7] Control holds four storage bits
// [R8] One instruction, stall, copy RAM page
// [R9] Page write end releases stall, clears bit
// [R10] Software loads address and RAM first
// [R11] Interrupts held pending during operation
// [R12] External reset deferred until operation ends
// [R13] Erase: one instruction, then stall
// [R14] Erase end releases stall, clears bit
// [R15] Software sets sector address first
// [R16] Bits 3,4 pick divider; reset gives 16
// [R17] Erase time n*5000/f plus 9 ms
// [R18] Software keeps erase at least 10 ms
// [R19] Write time n*5000/f plus 2 ms
// [R20] Software keeps write at least 3 ms
// [R21] Codes 00..11 give 16,8,4,2
// [R22] Count timing clock, then finish operation
module fspc_ctrl
  import fspc_pkg::*;
(
  input wire logic clock_in, // System clock, 25 MHz
  input wire logic reset_in, // Async reset, active high
  input wire logic [3:0] reg_addr_in, // Register address
  input wire logic [7:0] reg_wdata_in, // Write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  output logic [7:0] reg_rdata_out, // Read data, cycle after strobe
  input wire logic instr_done_in, // CPU finished an instruction
  output logic cpu_stall_out, // CPU hold request
  input wire logic irq_in, // Interrupt request from sources
  output logic irq_out, // Interrupt passed to CPU
  input wire logic external_reset_pin_in, // External reset request
  output logic sys_reset_out, // Reset passed to the system
  output fspc_ram_req_t ram_req_out, // Page RAM read
  input wire logic [7:0] ram_data_in, // RAM data, cycle after read
  output fspc_flash_req_t flash_req_out, // Flash array request
  output logic busy_out // Operation in progress
);

  typedef enum logic [2:0] {
    FSPC_IDLE,
    FSPC_WAIT_INSTR,
    FSPC_COPY,
    FSPC_TIMING,
    FSPC_FINISH
  } fspc_state_t;

  fspc_state_t state_r, state_nxt;
  logic [15:0] addr_r;
  logic gate_r;
  logic key_half_r;
  logic prg_r, ers_r;
  logic [1:0] sel_r;
  logic [7:0] rdata_r;
  logic [6:0] copy_idx_r;
  logic copy_wait_r;
  logic [3:0] div_cnt_r;
  fspc_op_t op_r;
  fspc_flash_req_t flash_r;
  logic [23:0] load_val;
  logic load_go;
  logic op_done;

  // Register decode
  wire wr_addr_lo = reg_wr_in && (reg_addr_in == `FSPC_ADDR_LO_OFS);
  wire wr_addr_hi = reg_wr_in && (reg_addr_in == `FSPC_ADDR_HI_OFS);
  wire wr_gate = reg_wr_in && (reg_addr_in == `FSPC_GATE_OFS);
  wire wr_ctrl_sel = reg_wr_in && (reg_addr_in == `FSPC_CTRL_OFS);
  // [R5] gate qualifies writes
  wire wr_ctrl = wr_ctrl_sel && gate_r && (state_r == FSPC_IDLE);
  wire key_first = wr_gate && (reg_wdata_in[3:0] == `FSPC_KEY_FIRST);
  wire key_second = wr_gate && (reg_wdata_in[3:0] == `FSPC_KEY_SECOND);
  wire busy = (state_r != FSPC_IDLE);

  // [R21] divider factor from select code
  wire [4:0] div_factor = (sel_r == 2'b00) ? 5'd16 :
                          (sel_r == 2'b01) ? 5'd8 :
                          (sel_r == 2'b10) ? 5'd4 : 5'd2;
  wire [3:0] div_last = 4'(div_factor - 5'd1);
  wire tick = busy && (div_cnt_r == div_last);
  // Fixed portions in system clocks; divided by n they become timing ticks
  wire [23:0] erase_fix_ticks = 24'(`FSPC_ERASE_FIX_CYC);
  wire [23:0] write_fix_ticks = 24'(`FSPC_WRITE_FIX_CYC);

  // [R17] erase: 5000 timing clocks plus fixed portion
  // [R19] write: 5000 timing clocks plus fixed portion
  always_comb begin
    load_val = 24'(`FSPC_DIV_BASE_CYC);
    if (op_r == FSPC_OP_ERASE) begin
      load_val = 24'(`FSPC_DIV_BASE_CYC) + 24'(erase_fix_ticks / {19'd0, div_factor});
    end else begin
      load_val = 24'(`FSPC_DIV_BASE_CYC) + 24'(write_fix_ticks / {19'd0, div_factor});
    end
  end

  // Next state logic
  always_comb begin
    state_nxt = state_r;
    load_go = 1'b0;
    unique case (state_r)
      FSPC_IDLE: begin
        // [R8] request arms the one-instruction window
        if (wr_ctrl && (reg_wdata_in[`FSPC_CTRL_PRG_BIT] || reg_wdata_in[`FSPC_CTRL_ERS_BIT])) begin
          state_nxt = FSPC_WAIT_INSTR;
        end
      end
      FSPC_WAIT_INSTR: begin
        // [R13] stall after the next instruction
        if (instr_done_in) begin
          state_nxt = (op_r == FSPC_OP_WRITE) ? FSPC_COPY : FSPC_TIMING;
          load_go = (op_r == FSPC_OP_ERASE);
        end
      end
      FSPC_COPY: begin
        if (copy_wait_r && (copy_idx_r == `FSPC_PAGE_BYTES - 7'd1)) begin
          state_nxt = FSPC_TIMING;
          load_go = 1'b1;
        end
      end
      FSPC_TIMING: begin
        // [R22] end after counted timing clocks
        if (op_done) state_nxt = FSPC_FINISH;
      end
      FSPC_FINISH: state_nxt = FSPC_IDLE;
    endcase
  end

  // Operation duration counter, counts timing clocks
  fspc_counter #(.W(24)) u_dur (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .load_in(load_go),
    .value_in(load_val),
    .tick_in(tick),
    .done_out(op_done)
  );

  // State and prescaler
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= FSPC_IDLE;
      div_cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      div_cnt_r <= (!busy || tick) ? 4'h0 : div_cnt_r + 4'h1;
    end
  end

  // Address register and unlock gate
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      addr_r <= `FSPC_ADDR_RST;
      gate_r <= 1'b0;
      key_half_r <= 1'b0;
    end else begin
      if (wr_addr_lo) addr_r[7:0] <= reg_wdata_in;
      if (wr_addr_hi) addr_r[15:8] <= reg_wdata_in;
      // [R3] back-to-back key pair
      if (reg_wr_in) key_half_r <= key_first;
      // [R4] gate closes when operation ends
      if (state_r == FSPC_FINISH) gate_r <= 1'b0;
      // A key pair landing in the same cycle wins over the clear
      if (key_second && key_half_r) gate_r <= 1'b1;
    end
  end

  // [R7] four control storage bits; [R16] reset selects 1/16
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      prg_r <= 1'b0;
      ers_r <= 1'b0;
      sel_r <= 2'b00;
      op_r <= FSPC_OP_NONE;
    end else if (wr_ctrl) begin
      prg_r <= reg_wdata_in[`FSPC_CTRL_PRG_BIT];
      ers_r <= reg_wdata_in[`FSPC_CTRL_ERS_BIT] && !reg_wdata_in[`FSPC_CTRL_PRG_BIT];
      sel_r <= {reg_wdata_in[`FSPC_CTRL_SEL_HI_BIT], reg_wdata_in[`FSPC_CTRL_SEL_LO_BIT]};
      op_r <= reg_wdata_in[`FSPC_CTRL_PRG_BIT] ? FSPC_OP_WRITE :
              reg_wdata_in[`FSPC_CTRL_ERS_BIT] ? FSPC_OP_ERASE : FSPC_OP_NONE;
    end else if (state_r == FSPC_FINISH) begin
      // [R9] [R14] clear request bit at end
      prg_r <= 1'b0;
      ers_r <= 1'b0;
      op_r <= FSPC_OP_NONE;
    end
  end

  // [R8] copy RAM 300H..33FH into the page
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      copy_idx_r <= 7'd0;
      copy_wait_r <= 1'b0;
      flash_r <= '0;
    end else begin
      flash_r.write_pulse <= 1'b0;
      flash_r.erase_pulse <= 1'b0;
      if (state_r == FSPC_COPY) begin
        copy_wait_r <= !copy_wait_r;
        if (copy_wait_r) begin
          flash_r.write_pulse <= 1'b1;
          flash_r.addr <= {addr_r[15:6], copy_idx_r[5:0]};
          flash_r.data <= ram_data_in;
          copy_idx_r <= copy_idx_r + 7'd1;
        end
      end else begin
        copy_idx_r <= 7'd0;
        copy_wait_r <= 1'b0;
      end
      // [R1] sector from bits 15:10
      if (load_go && (op_r == FSPC_OP_ERASE)) begin
        flash_r.erase_pulse <= 1'b1;
        flash_r.addr <= {addr_r[15:10], 10'h000};
      end
    end
  end

  // [R2] read mux, missing bits read one
  wire [7:0] ctrl_view = {3'b111, sel_r, 1'b1, ers_r, prg_r};
  wire [7:0] gate_view = {7'h7f, gate_r};
  wire [7:0] stat_view = {7'h7f, busy};
  wire [7:0] rd_mux = (reg_addr_in == `FSPC_ADDR_LO_OFS) ? {addr_r[7:6], 6'h3f} :
                      (reg_addr_in == `FSPC_ADDR_HI_OFS) ? addr_r[15:8] :
                      (reg_addr_in == `FSPC_GATE_OFS) ? gate_view :
                      (reg_addr_in == `FSPC_CTRL_OFS) ? ctrl_view :
                      (reg_addr_in == `FSPC_STAT_OFS) ? stat_view : 8'hff;

  // Read data register
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) rdata_r <= 8'h00;
    else if (reg_rd_in) rdata_r <= rd_mux;
  end

  // Outputs; stall spans copy, timing and finish
  wire stall = (state_r == FSPC_COPY) || (state_r == FSPC_TIMING) || (state_r == FSPC_FINISH);
  assign reg_rdata_out = rdata_r;
  assign cpu_stall_out = stall;
  // [R11] interrupts held while stalled
  assign irq_out = irq_in && !stall;
  // [R12] reset deferred while stalled
  assign sys_reset_out = external_reset_pin_in && !stall;
  assign ram_req_out.rd = (state_r == FSPC_COPY) && !copy_wait_r;
  assign ram_req_out.addr = `FSPC_RAM_BASE + {10'h000, copy_idx_r[5:0]};
  assign flash_req_out = flash_r;
  assign busy_out = busy;

endmodule : fspc_ctrl

/* testbench/fspc_ctrl_asserts.sv */
`timescale 1ns/1ps
// Port-level properties of the flash sequencer
module fspc_chk
  import fspc_pkg::*;
(
  input wire logic clock_in, // System clock
  input wire logic reset_in, // Async reset
  input wire logic [3:0] reg_addr_in, // Register index
  input wire logic reg_rd_in, // Read strobe
  input wire logic [7:0] reg_rdata_out, // Read data
  input wire logic instr_done_in, // Instruction done
  input wire logic cpu_stall_out, // CPU hold
  input wire logic irq_in, // Interrupt in
  input wire logic irq_out, // Interrupt out
  input wire logic external_reset_pin_in, // Reset pin
  input wire logic sys_reset_out, // Reset out
  input fspc_ram_req_t ram_req_out, // RAM read
  input fspc_flash_req_t flash_req_out, // Flash request
  input wire logic busy_out // Busy
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // Gating of interrupts and reset around the stall
  a_irq_held: assert property (cpu_stall_out |-> !irq_out)
    else $error("interrupt passed during stall");
  a_irq_pass: assert property (!cpu_stall_out |-> irq_out == irq_in)
    else $error("interrupt lost outside stall");
  a_rst_defer: assert property (cpu_stall_out |-> !sys_reset_out)
    else $error("reset passed during stall");
  a_rst_pass: assert property (!cpu_stall_out |-> sys_reset_out == external_reset_pin_in)
    else $error("reset lost outside stall");
  // Missing bits read as one
  a_ctrl_ones: assert property (reg_rd_in && reg_addr_in == 4'h3 |=> (reg_rdata_out & 8'he4) == 8'he4)
    else $error("control spare bits not one");
  a_addr_ones: assert property (reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out[5:0] == 6'h3f)
    else $error("address spare bits not one");
  // Stall only after the one instruction
  a_stall_cause: assert property ($rose(cpu_stall_out) |-> $past(instr_done_in) && busy_out)
    else $error("stall without instruction");
  a_erase_once: assert property (flash_req_out.erase_pulse |=> !flash_req_out.erase_pulse [*8])
    else $error("erase pulse repeated");
  a_write_held: assert property (flash_req_out.write_pulse |-> cpu_stall_out)
    else $error("flash write outside stall");
  a_ram_window: assert property (ram_req_out.rd |-> ram_req_out.addr[15:6] == 10'h00c)
    else $error("RAM read outside page window");
  c_stall_end: cover property ($fell(cpu_stall_out));
  c_erase: cover property (flash_req_out.erase_pulse);
  c_write: cover property (flash_req_out.write_pulse);
endmodule : fspc_chk

bind fspc_ctrl fspc_chk u_chk (.clock_in(clock_in), .reset_in(reset_in),
  .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .instr_done_in(instr_done_in), .cpu_stall_out(cpu_stall_out), .irq_in(irq_in),
  .irq_out(irq_out), .external_reset_pin_in(external_reset_pin_in),
  .sys_reset_out(sys_reset_out), .ram_req_out(ram_req_out),
  .flash_req_out(flash_req_out), .busy_out(busy_out));

/* testbench/fspc_cpu_model.sv */
`timescale 1ns/1ps
// CPU and page RAM seen from the sequencer
module fspc_cpu_model
  import fspc_pkg::*;
(
  input wire logic clock_in, // System clock
  input wire logic step_in, // Run one instruction
  input fspc_ram_req_t ram_req_in, // RAM read request
  output logic [7:0] ram_data_out = 8'h00, // RAM data
  output logic instr_done_out = 1'b0 // Instruction finished
);
  // page data is the address low byte XOR A5
  // Data is valid only after a read, otherwise it toggles
  always @(posedge clock_in) begin
    ram_data_out <= ram_req_in.rd ? (ram_req_in.addr[7:0] ^ 8'ha5) : ~ram_data_out;
    instr_done_out <= step_in;
  end
endmodule : fspc_cpu_model

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import fspc_pkg::*;
  logic clock_in = 0, reset_in = 1, wr_s = 0, rd_s = 0, irq = 0, ext = 0, step = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, ram_data;
  logic stall, busy, irq_o, rst_o, done;
  fspc_ram_req_t ram_req;
  fspc_flash_req_t fl;
  int errors = 0, total_checks = 0, nwr = 0, ners = 0, cnt;

  fspc_ctrl u_dut (.clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .instr_done_in(done), .cpu_stall_out(stall), .irq_in(irq), .irq_out(irq_o),
    .external_reset_pin_in(ext), .sys_reset_out(rst_o), .ram_req_out(ram_req),
    .ram_data_in(ram_data), .flash_req_out(fl), .busy_out(busy));
  fspc_cpu_model u_cpu (.clock_in(clock_in), .step_in(step), .ram_req_in(ram_req),
    .ram_data_out(ram_data), .instr_done_out(done));

  always #20 clock_in = ~clock_in;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task close_out;
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_in);
    wr_s <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_in);
    rd_s <= 1'b0;
    #1 check(rdata, e);
  endtask : rd
  task unlock;
    wr(4'h2, 8'h15);
    wr(4'h2, 8'h7a);
  endtask : unlock
  // One instruction done, then the stall must stand
  task run_one;
    repeat (4) @(posedge clock_in);
    step <= 1'b1;
    #1 check(stall, 1'b0);
    @(posedge clock_in);
    step <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1 check(stall, 1'b1);
  endtask : run_one

  // Flash traffic monitor, sampled away from the launching edge
  always @(negedge clock_in) begin
    if (fl.write_pulse === 1'b1) begin
      check(fl.data, {2'b00, fl.addr[5:0]} ^ 8'ha5);
      check(fl.addr[15:6], 10'h155);
      nwr++;
    end
    if (fl.erase_pulse === 1'b1) begin
      check(fl.addr[15:10], 6'h15);
      ners++;
    end
  end

  initial begin
    #4000000;
    errors++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(4'h0, 8'h3f);
    rd(4'h3, 8'he4);
    rd(4'hf, 8'hff);
    wr(4'h3, 8'h18);
    rd(4'h3, 8'he4);
    wr(4'h2, 8'h05);
    wr(4'h2, 8'h0b);
    wr(4'h3, 8'h18);
    rd(4'h3, 8'he4);
    for (int c = 0; c < 4; c++) begin
      unlock();
      wr(4'h3, 8'(c << 3));
      rd(4'h3, 8'he4 | 8'(c << 3));
    end
    wr(4'h1, 8'h55);
    wr(4'h0, 8'h40);
    unlock();
    wr(4'h3, 8'h09);
    run_one();
    @(posedge clock_in);
    irq <= 1'b1;
    ext <= 1'b1;
    @(posedge clock_in);
    #1 check(irq_o, 1'b0);
    check(rst_o, 1'b0);
    @(posedge clock_in);
    irq <= 1'b0;
    ext <= 1'b0;
    cnt = 6;
    while (stall === 1'b1 && cnt < 95000) begin
      @(posedge clock_in);
      cnt++;
    end
    // Code 01 write: 8*5000 cycles, 2 ms fixed, 128 copy cycles, 256-cycle resolution
    check(cnt / 256, (8 * 5000 + 50000 + 128) / 256);
    check(nwr, 64);
    rd(4'h3, 8'hec);
    wr(4'h3, 8'h1b);
    rd(4'h3, 8'hec);
    wr(4'h1, 8'h57);
    wr(4'h0, 8'hc0);
    unlock();
    wr(4'h3, 8'h02);
    run_one();
    check(busy, 1'b1);
    repeat (20) @(posedge clock_in);
    check(ners, 1);
    // Mid-run system reset aborts the erase and restores the control view
    reset_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(4'h3, 8'he4);
    close_out();
  end
endmodule : testbench
